// ---- design/pet_core.sv ----
// Purpose: external start/stop/clear and emergency stop for a coupled pwm pair
// Assumes: trigger inputs synchronous to aclk; one pwm tick doubles as sample clock
// Notes:   outputs registered; counter core kept minimal (period/duty compare)
`timescale 1ns/100ps
module pet_core #(
  parameter int CNT_W = 16
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // trigger pins
  input  wire logic        trigger_event_in0,
  input  wire logic        trigger_event_in1,
  // pwm outputs and interrupt
  output logic             pwm_out_a,
  output logic             pwm_out_b,
  output logic             pwm_channel_irq
);

  typedef struct packed {
    logic                   awready;
    logic                   wready;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   arready;
    logic                   rvalid;
    logic [1:0]             rresp;
    logic [31:0]            rdata;
    logic                   aw_have;
    logic [7:0]             awaddr;
    logic                   w_have;
    logic [31:0]            wdata;
    logic [3:0]             wstrb;
    logic [pet_pkg::CTRL_W-1:0] ctrl;
    logic [CNT_W-1:0]       duty;
    logic [CNT_W-1:0]       period;
    logic [CNT_W-1:0]       duty_buffer;
    logic [CNT_W-1:0]       period_buffer;
    logic [CNT_W-1:0]       cnt;
    logic                   flag;
    pet_pkg::pet_state_e    state;
    logic [pet_pkg::DIV_W-1:0] div;
    logic                   tick;
    logic                   s_a;
    logic                   s_b;
    logic                   filt;
    logic                   filt_prev;
    logic                   ext_run;
    logic                   estop;
    logic                   irq;
    logic                   reload_pend;
    logic                   out_a;
    logic                   out_b;
  } pet_st_s;

  pet_st_s st_q;
  pet_st_s st_d;

  ////////////////////////////////////////////////////////////////////////////////
  // decoded controls
  logic       run_bit;
  logic [1:0] mode;
  logic [1:0] pol;
  logic [1:0] ese;
  logic       rise;
  logic       fall;
  logic       start_edge;
  logic       stop_edge;
  logic       start_level;
  logic       estop_ev;
  logic       ext_clr;
  logic       count_go;
  logic       wr_fire;
  logic       wr_duty_per;
  logic [pet_pkg::DIV_W-1:0] div_lim;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  assign run_bit  = st_q.ctrl[pet_pkg::B_RUN];
  assign mode     = {st_q.ctrl[pet_pkg::B_STM_HI], st_q.ctrl[pet_pkg::B_STM_LO]};
  assign pol      = {st_q.ctrl[pet_pkg::B_POL_HI], st_q.ctrl[pet_pkg::B_POL_LO]};
  assign ese      = {st_q.ctrl[pet_pkg::B_ESE_HI], st_q.ctrl[pet_pkg::B_ESE_LO]};
  assign div_lim  = ({st_q.ctrl[pet_pkg::B_CS_HI], st_q.ctrl[pet_pkg::B_CS_LO]}
                     == pet_pkg::CS_OSC) ? pet_pkg::DIV_W'(pet_pkg::OSC_CYC - 1)
                                         : pet_pkg::DIV_W'(pet_pkg::LS_CYC - 1);
  assign rise     = st_q.filt & ~st_q.filt_prev;
  assign fall     = ~st_q.filt & st_q.filt_prev;
  assign start_edge  = (pol == pet_pkg::POL_RISE) ? rise : fall;
  assign stop_edge   = (pol == pet_pkg::POL_RISE) ? fall : rise;
  assign start_level = (pol == pet_pkg::POL_RISE) ? st_q.filt : ~st_q.filt;
  // estop edge choice, coupled mode only
  assign estop_ev = st_q.ctrl[pet_pkg::B_COUPLED] && ese != pet_pkg::ESE_OFF &&
                    ((ese == pet_pkg::ESE_FALL) ? fall :
                     (ese == pet_pkg::ESE_RISE) ? rise : (rise | fall));
  assign ext_clr = run_bit && stop_edge &&
                   ((mode == pet_pkg::MODE_SWEXT) || (mode == pet_pkg::MODE_EXT) ||
                    (mode == pet_pkg::MODE_CLR &&
                     (!st_q.flag || st_q.ctrl[pet_pkg::B_CLRGATE])));
  assign wr_fire     = st_q.aw_have && st_q.w_have && !st_q.bvalid;
  assign wr_duty_per = wr_fire &&
                       (st_q.awaddr == pet_pkg::OFS_DUTY || st_q.awaddr == pet_pkg::OFS_PERIOD);

  always_comb begin
    case (mode)
      pet_pkg::MODE_SW:    count_go = run_bit;
      pet_pkg::MODE_SWEXT: count_go = run_bit && start_level;
      pet_pkg::MODE_EXT:   count_go = run_bit && st_q.ext_run;
      pet_pkg::MODE_CLR:   count_go = run_bit;
      default:             count_go = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    st_d           = st_q;
    st_d.irq       = 1'b0;
    st_d.filt_prev = st_q.filt;
    // sample clock divider
    st_d.tick = 1'b0;
    if (st_q.div >= div_lim) begin
      st_d.div  = '0;
      st_d.tick = 1'b1;
    end else begin
      st_d.div = st_q.div + 1'b1;
    end
    // two agreeing samples needed, so a one-sample glitch never passes
    if (st_q.tick) begin
      st_d.s_a = st_q.ctrl[pet_pkg::B_TSEL] ? trigger_event_in1 : trigger_event_in0;
      st_d.s_b = st_q.s_a;
    end
    if (st_q.s_a == st_q.s_b) begin
      st_d.filt = st_q.s_b;
    end
    // axi write channels, taken in either order
    if (s_axi_awvalid && st_q.awready) begin
      st_d.aw_have = 1'b1;
      st_d.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_q.wready) begin
      st_d.w_have = 1'b1;
      st_d.wdata  = s_axi_wdata;
      st_d.wstrb  = s_axi_wstrb;
    end
    if (st_q.bvalid && s_axi_bready) begin
      st_d.bvalid = 1'b0;
    end
    if (wr_fire) begin
      st_d.aw_have = 1'b0;
      st_d.w_have  = 1'b0;
      st_d.bvalid  = 1'b1;
      st_d.bresp   = pet_pkg::RESP_OKAY;
      case (st_q.awaddr)
        pet_pkg::OFS_CTRL:
          st_d.ctrl = pet_pkg::CTRL_W'(merge(32'(st_q.ctrl), st_q.wdata, st_q.wstrb));
        pet_pkg::OFS_DUTY: begin
          st_d.duty = CNT_W'(merge(32'(st_q.duty), st_q.wdata, st_q.wstrb));
          if (st_q.state == pet_pkg::ST_IDLE) begin
            st_d.duty_buffer = st_d.duty;
          end
        end
        pet_pkg::OFS_PERIOD: begin
          st_d.period = CNT_W'(merge(32'(st_q.period), st_q.wdata, st_q.wstrb));
          if (st_q.state == pet_pkg::ST_IDLE) begin
            st_d.period_buffer = st_d.period;
          end
        end
        pet_pkg::OFS_STATUS: begin
          // write one clears; a new estop below still wins
          if (st_q.wstrb[2] && st_q.wdata[pet_pkg::B_ST_ESTOP]) begin
            st_d.estop = 1'b0;
          end
        end
        pet_pkg::OFS_BUF: ;
        default: st_d.bresp = pet_pkg::RESP_SLV;
      endcase
    end
    // axi read
    if (st_q.rvalid && s_axi_rready) begin
      st_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st_q.arready) begin
      st_d.rvalid = 1'b1;
      st_d.rresp  = pet_pkg::RESP_OKAY;
      case (s_axi_araddr)
        pet_pkg::OFS_CTRL:   st_d.rdata = 32'(st_q.ctrl);
        pet_pkg::OFS_DUTY:   st_d.rdata = 32'(st_q.duty);
        pet_pkg::OFS_PERIOD: st_d.rdata = 32'(st_q.period);
        pet_pkg::OFS_STATUS: st_d.rdata = {13'h0000, st_q.state != pet_pkg::ST_IDLE,
                                           st_q.estop, st_q.flag, 16'(st_q.cnt)};
        pet_pkg::OFS_BUF:    st_d.rdata = {16'(st_q.period_buffer), 16'(st_q.duty_buffer)};
        default: begin
          st_d.rdata = 32'h0000_0000;
          st_d.rresp = pet_pkg::RESP_SLV;
        end
      endcase
    end
    // edge-only mode keeps its own run latch
    if (mode != pet_pkg::MODE_EXT || !run_bit) begin
      st_d.ext_run = 1'b0;
    end else if (start_edge) begin
      st_d.ext_run = 1'b1;
    end else if (stop_edge) begin
      st_d.ext_run = 1'b0;
    end
    // arm on first pwm tick, count from the second
    if (st_q.tick) begin
      case (st_q.state)
        pet_pkg::ST_IDLE: if (count_go && !st_q.estop) st_d.state = pet_pkg::ST_ARM;
        pet_pkg::ST_ARM: begin
          st_d.state = count_go ? pet_pkg::ST_RUN : pet_pkg::ST_IDLE;
          if (count_go && st_q.cnt != st_q.period_buffer) st_d.cnt = st_q.cnt + 1'b1;
        end
        pet_pkg::ST_RUN: begin
          if (!count_go) begin
            st_d.state = pet_pkg::ST_IDLE;
          end else if (st_q.cnt == st_q.period_buffer) begin
            st_d.cnt           = '0;
            st_d.flag          = 1'b1;
            st_d.duty_buffer   = st_q.duty;
            st_d.period_buffer = st_q.period;
          end else begin
            st_d.cnt = st_q.cnt + 1'b1;
            if (st_q.cnt == st_q.duty_buffer) begin
              st_d.flag = 1'b0;
            end
          end
        end
        default: st_d.state = pet_pkg::ST_IDLE;
      endcase
      // deferred reload lands on the next pwm tick
      if (st_q.reload_pend) begin
        st_d.reload_pend   = 1'b0;
        st_d.duty_buffer   = st_q.duty;
        st_d.period_buffer = st_q.period;
      end
    end
    // external clear restarts the period and reloads
    if (ext_clr) begin
      st_d.cnt  = '0;
      st_d.flag = 1'b1;
      if (mode != pet_pkg::MODE_CLR) begin
        st_d.state = pet_pkg::ST_IDLE;
      end
      if (wr_duty_per) begin
        st_d.reload_pend = 1'b1;
      end else begin
        st_d.duty_buffer   = st_q.duty;
        st_d.period_buffer = st_q.period;
      end
    end
    if (estop_ev) begin
      st_d.estop = 1'b1;
      st_d.irq   = 1'b1;
      st_d.cnt   = '0;
      st_d.flag  = 1'b0;
      st_d.state = pet_pkg::ST_IDLE;
    end
    // handshake readies and pwm outputs, registered so they never depend on inputs
    st_d.awready = !st_d.aw_have && !st_d.bvalid;
    st_d.wready  = !st_d.w_have && !st_d.bvalid;
    st_d.arready = !st_d.rvalid;
    st_d.out_a   = st_d.flag && !st_d.estop;
    st_d.out_b   = !st_d.flag && st_d.state == pet_pkg::ST_RUN && !st_d.estop;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q        <= '0;
      st_q.ctrl   <= pet_pkg::CTRL_RST;
      st_q.duty   <= pet_pkg::DUTY_RST;
      st_q.period <= pet_pkg::PERIOD_RST;
      st_q.flag   <= 1'b1;
      st_q.state  <= pet_pkg::ST_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  assign s_axi_awready   = st_q.awready;
  assign s_axi_wready    = st_q.wready;
  assign s_axi_bvalid    = st_q.bvalid;
  assign s_axi_bresp     = st_q.bresp;
  assign s_axi_arready   = st_q.arready;
  assign s_axi_rvalid    = st_q.rvalid;
  assign s_axi_rresp     = st_q.rresp;
  assign s_axi_rdata     = st_q.rdata;
  assign pwm_out_a       = st_q.out_a;
  assign pwm_out_b       = st_q.out_b;
  assign pwm_channel_irq = st_q.irq;
  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_filter_agree: assert property ($changed(st_q.filt)
                                   |-> $past(st_q.s_a) == $past(st_q.s_b))
    else $error("filtered level moved without two agreeing samples");
  a_sample_period: assert property (st_q.tick && div_lim != 0 |=> !st_q.tick)
    else $error("sample tick repeated too soon");
  a_sw_mode_idle: assert property (mode == pet_pkg::MODE_SW && !run_bit && st_q.tick
                                   |=> st_q.state == pet_pkg::ST_IDLE)
    else $error("software mode kept running with run bit low");
  a_stop_level_hold: assert property (mode == pet_pkg::MODE_SWEXT && !start_level
                                      && st_q.state == pet_pkg::ST_IDLE && st_q.tick
                                      |=> st_q.state == pet_pkg::ST_IDLE)
    else $error("counter armed at stop level");
  a_ext_clear: assert property (ext_clr && !estop_ev |=> st_q.cnt == '0 && st_q.flag)
    else $error("external clear did not zero the counter");
  a_clear_reload: assert property (ext_clr && !wr_duty_per
                                   |=> st_q.duty_buffer == $past(st_q.duty)
                                       && st_q.period_buffer == $past(st_q.period))
    else $error("buffers not reloaded on external clear");
  a_ext_norun: assert property (mode == pet_pkg::MODE_EXT && !run_bit |=> !st_q.ext_run)
    else $error("edge mode latched run without run bit");
  a_clear_gate: assert property (mode == pet_pkg::MODE_CLR && st_q.flag
                                 && !st_q.ctrl[pet_pkg::B_CLRGATE] |-> !ext_clr)
    else $error("clear accepted while gated");
  a_arm_step: assert property (st_q.state == pet_pkg::ST_ARM && st_q.tick && count_go
                               && st_q.cnt != st_q.period_buffer && !estop_ev && !ext_clr
                               |=> st_q.state == pet_pkg::ST_RUN
                                   && st_q.cnt == CNT_W'($past(st_q.cnt) + 1'b1))
    else $error("arm did not move to counting");
  a_estop_effect: assert property (estop_ev |=> st_q.estop && pwm_channel_irq
                                   && st_q.cnt == '0 && !pwm_out_a && !pwm_out_b)
    else $error("emergency stop incomplete");
  a_estop_release: assert property (estop_ev ##1 !estop_ev[*2] |-> st_q.estop
                                    || $past(wr_fire))
    else $error("estop flag dropped without a write");
  c_estop:    cover property (estop_ev ##1 pwm_channel_irq);
  c_mode01:   cover property (mode == pet_pkg::MODE_SWEXT && st_q.state == pet_pkg::ST_RUN);
  c_mode11:   cover property (mode == pet_pkg::MODE_CLR && ext_clr);
  c_deferred: cover property (st_q.reload_pend);
endmodule // pet_core

// ---- design/pet_pkg.sv ----
// Purpose: constants for the external trigger / emergency stop pwm pair block
// Assumes: 25 MHz aclk, AXI4-Lite register access, 32-bit aligned words
// Notes:   field positions and encodings are local choices
package pet_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_DUTY   = 8'h04;
  localparam logic [7:0] OFS_PERIOD = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_BUF    = 8'h10;
  // control field positions
  localparam int B_RUN     = 0;
  localparam int B_STM_LO  = 1;
  localparam int B_STM_HI  = 2;
  localparam int B_TSEL    = 3;
  localparam int B_POL_LO  = 4;
  localparam int B_POL_HI  = 5;
  localparam int B_CS_LO   = 6;
  localparam int B_CS_HI   = 7;
  localparam int B_CLRGATE = 8;
  localparam int B_COUPLED = 9;
  localparam int B_ESE_LO  = 10;
  localparam int B_ESE_HI  = 11;
  localparam int CTRL_W    = 12;
  // status field positions
  localparam int B_ST_FLAG  = 16;
  localparam int B_ST_ESTOP = 17;
  localparam int B_ST_RUN   = 18;
  // reset values
  localparam logic [11:0] CTRL_RST   = 12'h000;
  localparam logic [15:0] DUTY_RST   = 16'h0000;
  localparam logic [15:0] PERIOD_RST = 16'hffff;
  // encodings
  localparam logic [1:0] MODE_SW    = 2'b00;
  localparam logic [1:0] MODE_SWEXT = 2'b01;
  localparam logic [1:0] MODE_EXT   = 2'b10;
  localparam logic [1:0] MODE_CLR   = 2'b11;
  localparam logic [1:0] POL_RISE   = 2'b01;
  localparam logic [1:0] CS_OSC     = 2'b00;
  localparam logic [1:0] ESE_OFF    = 2'b00;
  localparam logic [1:0] ESE_FALL   = 2'b01;
  localparam logic [1:0] ESE_RISE   = 2'b10;
  localparam logic [1:0] RESP_OKAY  = 2'b00;
  localparam logic [1:0] RESP_SLV   = 2'b10;
  // timing: sampling periods, counted down to whole aclk cycles
  localparam int CLK_NS     = 40;
  localparam int OSC_NS     = 125;
  localparam int LS_NS      = 30500;
  localparam int OSC_CYC    = (OSC_NS / CLK_NS) < 1 ? 1 : OSC_NS / CLK_NS;
  localparam int LS_CYC     = (LS_NS / CLK_NS) < 1 ? 1 : LS_NS / CLK_NS;
  localparam int DIV_W      = 10;
  typedef enum logic [1:0] {ST_IDLE, ST_ARM, ST_RUN} pet_state_e;
endpackage : pet_pkg

// ---- tb/pet_trig_src.sv ----
// Purpose: trigger pin source facing the pet block
// Assumes: pins change just after a rising aclk edge
// Notes:   short holds only when the bench asks for a glitch
`timescale 1ns/100ps
module pet_trig_src (
  // clock
  input  wire logic aclk,
  // trigger pins
  output logic      trigger_event_in0,
  output logic      trigger_event_in1
);
  initial begin
    trigger_event_in0 = 1'b1;
    trigger_event_in1 = 1'b0;
  end
  task automatic drive(input logic ch, input logic lvl, input int hold);
    if (ch) trigger_event_in1 <= lvl;
    else trigger_event_in0 <= lvl;
    repeat (hold) @(posedge aclk);
  endtask
endmodule // pet_trig_src

// ---- tb/pwm_ext_trigger_estop_bench.sv ----
// Purpose: self-checking bench for the trigger / emergency stop block
// Assumes: oscillator sampling outside the slow-sampling check, so a 12-cycle level is seen there
// Notes:   irq pulses are counted on every rising aclk edge, checked as deltas
`timescale 1ns/100ps
module pwm_ext_trigger_estop_bench;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, trigger_event_in0, trigger_event_in1, pwm_out_a, pwm_out_b;
  logic        pwm_channel_irq;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, v, c1;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          bad_count, checks_done, cycles, irq_seen;

  pet_core uut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .trigger_event_in0, .trigger_event_in1, .pwm_out_a, .pwm_out_b, .pwm_channel_irq
  );
  pet_trig_src src (.aclk, .trigger_event_in0, .trigger_event_in1);

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  // the irq is a one-cycle pulse, so it is counted here rather than polled
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (pwm_channel_irq === 1'b1) irq_seen <= irq_seen + 1;
    if (cycles == 5000) begin
      bad_count++;
      wrap_up();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    if (bad_count == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s: got %h exp %h", $time, msg, got, exp);
    end
  endtask
  // one leading edge keeps a strobe from being written twice in one step
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, input logic [3:0] s = 4'hf,
                     input logic [1:0] er = 2'b00);
    @(posedge aclk);
    if (w) begin
      {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, s};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    end else begin
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
    end
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while ((w ? s_axi_bvalid : s_axi_rvalid) !== 1'b1);
    q = s_axi_rdata;
    {s_axi_bready, s_axi_rready} <= 2'h0;
    check({30'h0, w ? s_axi_bresp : s_axi_rresp}, {30'h0, er}, "resp");
  endtask
  task automatic ctl(input logic [31:0] d);
    bus(1'b1, pet_pkg::OFS_CTRL, d, v);
  endtask
  task automatic st();
    bus(1'b0, pet_pkg::OFS_STATUS, 32'h0, v);
  endtask
  task automatic cnt_is(input logic zero, input string msg);
    st();
    check({31'h0, v[15:0] == 16'h0}, {31'h0, zero}, msg);
  endtask
  task automatic flag_is(input logic exp, input string msg);
    st();
    check({31'h0, v[pet_pkg::B_ST_ESTOP]}, {31'h0, exp}, msg);
  endtask
  function automatic logic [31:0] cv(logic [1:0] m, logic t, logic r,
                                     logic [1:0] e = 2'b00, logic c = 1'b0);
    cv = 32'h0;
    cv[pet_pkg::B_RUN] = r;
    cv[pet_pkg::B_STM_HI:pet_pkg::B_STM_LO] = m;
    cv[pet_pkg::B_TSEL] = t;
    cv[pet_pkg::B_POL_HI:pet_pkg::B_POL_LO] = pet_pkg::POL_RISE;
    cv[pet_pkg::B_COUPLED] = c;
    cv[pet_pkg::B_ESE_HI:pet_pkg::B_ESE_LO] = e;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    bus(1'b0, pet_pkg::OFS_CTRL, 32'h0, v);
    check(v, {20'h0, pet_pkg::CTRL_RST}, "ctrl rst");
    bus(1'b1, 8'h40, 32'h0000_0001, v, 4'hf, pet_pkg::RESP_SLV);
    bus(1'b0, 8'h40, 32'h0, v, 4'hf, pet_pkg::RESP_SLV);
    check(v, 32'h0, "unmapped");
  endtask
  task automatic t_swext();
    bus(1'b1, pet_pkg::OFS_DUTY, 32'h0000_0012, v);
    bus(1'b1, pet_pkg::OFS_PERIOD, 32'h0000_0200, v);
    ctl(cv(2'b01, 1'b1, 1'b1));
    repeat (30) @(posedge aclk);
    cnt_is(1'b1, "stop level");
    src.drive(1'b1, 1'b1, 30);
    cnt_is(1'b0, "start level");
    // duty change on fast sampling pairing
    bus(1'b1, pet_pkg::OFS_DUTY, 32'h0000_0034, v);
    src.drive(1'b1, 1'b0, 15);
    cnt_is(1'b1, "stop clears");
    bus(1'b0, pet_pkg::OFS_BUF, 32'h0, v);
    check(v, 32'h0200_0034, "reload");
  endtask
  task automatic t_ext();
    ctl(cv(2'b10, 1'b1, 1'b0));
    src.drive(1'b1, 1'b1, 15);
    cnt_is(1'b1, "no run");
    src.drive(1'b1, 1'b0, 15);
    ctl(cv(2'b10, 1'b1, 1'b1));
    repeat (15) @(posedge aclk);
    cnt_is(1'b1, "no edge");
    src.drive(1'b1, 1'b1, 30);
    cnt_is(1'b0, "start edge");
    src.drive(1'b1, 1'b0, 15);
    cnt_is(1'b1, "stop edge");
    ctl(32'h0);
  endtask
  // edge clear, gated while flag high
  task automatic t_clr();
    ctl(cv(2'b11, 1'b0, 1'b1));
    bus(1'b1, pet_pkg::OFS_DUTY, 32'h0000_0056, v);
    st();
    c1 = v;
    src.drive(1'b0, 1'b0, 12);
    st();
    check({31'h0, v[15:0] > c1[15:0]}, 32'h1, "gated");
    src.drive(1'b0, 1'b1, 12);
    ctl(cv(2'b11, 1'b0, 1'b1) | (32'h1 << pet_pkg::B_CLRGATE));
    st();
    c1 = v;
    src.drive(1'b0, 1'b0, 12);
    st();
    check({31'h0, v[15:0] < c1[15:0]}, 32'h1, "cleared");
    bus(1'b0, pet_pkg::OFS_BUF, 32'h0, v);
    check(v, 32'h0200_0056, "clr reload");
  endtask
  task automatic t_sw();
    ctl(cv(2'b00, 1'b0, 1'b1));
    st();
    c1 = v;
    src.drive(1'b0, 1'b1, 15);
    src.drive(1'b0, 1'b0, 15);
    st();
    check({31'h0, v[15:0] > c1[15:0]}, 32'h1, "pins ignored");
    src.drive(1'b0, 1'b1, 15);
  endtask
  task automatic t_pol();
    ctl(cv(2'b01, 1'b0, 1'b1) ^ (32'h3 << pet_pkg::B_POL_LO));
    repeat (10) @(posedge aclk);
    st();
    check({31'h0, v[pet_pkg::B_ST_RUN]}, 32'h0, "high is stop level");
    src.drive(1'b0, 1'b0, 30);
    st();
    check({31'h0, v[pet_pkg::B_ST_RUN]}, 32'h1, "low is start level");
    src.drive(1'b0, 1'b1, 15);
    cnt_is(1'b1, "rising stop clears");
  endtask
  task automatic t_estop();
    int base;
    ctl(cv(2'b00, 1'b0, 1'b1, 2'b01));
    src.drive(1'b0, 1'b0, 15);
    src.drive(1'b0, 1'b1, 15);
    flag_is(1'b0, "uncoupled");
    ctl(cv(2'b00, 1'b0, 1'b1, 2'b01, 1'b1));
    src.drive(1'b0, 1'b0, 2);
    src.drive(1'b0, 1'b1, 15);
    flag_is(1'b0, "glitch");
    // slow sampling misses a short level
    ctl(cv(2'b00, 1'b0, 1'b1, 2'b01, 1'b1) | (32'h1 << pet_pkg::B_CS_LO));
    src.drive(1'b0, 1'b0, 30);
    src.drive(1'b0, 1'b1, 15);
    flag_is(1'b0, "slow sampling");
    for (int e = 1; e < 4; e++) begin
      ctl(cv(2'b00, 1'b0, 1'b1, e[1:0], 1'b1));
      for (int l = 0; l < 2; l++) begin
        base = irq_seen;
        src.drive(1'b0, l[0], 15);
        flag_is(e[l], "edge sel");
        check(irq_seen - base, {31'h0, e[l]}, "irq");
        if (e[l]) check({v[15:0], 14'h0, pwm_out_a, pwm_out_b}, 32'h0, "off");
        bus(1'b1, pet_pkg::OFS_STATUS, 32'h1 << pet_pkg::B_ST_ESTOP, v, 4'b0100);
        flag_is(1'b0, "w1c");
      end
    end
  endtask

  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
    aresetn = 1'b0;
    bad_count = 0;
    checks_done = 0;
    cycles = 0;
    irq_seen = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_reset();
    t_swext();
    t_ext();
    t_clr();
    t_sw();
    t_pol();
    t_estop();
    wrap_up();
  end
endmodule // pwm_ext_trigger_estop_bench
